// [hw/pmic_cond_sync.sv]
module pmic_cond_sync #(
  parameter int unsigned WIDTH  = 1,
  parameter bit          STICKY = 1'b0
) (
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic [WIDTH-1:0] raw_i,
  input  wire logic             clear_i,
  output logic      [WIDTH-1:0] value_o
);

  initial begin
    if (WIDTH < 1) begin
      $error("pmic_cond_sync: WIDTH must be at least 1");
    end
  end

  // ==========================================================
  // two-stage synchroniser; stage one is read only by stage two
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] value_q;
  logic [WIDTH-1:0] value_d;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= raw_i;
      sync_q <= meta_q;
    end
  end

  // ==========================================================
  // sticky mode: a condition seen during the clearing read survives
  assign value_d = STICKY ? ((value_q & ~{WIDTH{clear_i}}) | sync_q) : sync_q;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      value_q <= '0;
    end else begin
      value_q <= value_d;
    end
  end

  assign value_o = value_q;

endmodule // pmic_cond_sync

// [hw/pmic_ctrl_regs.sv]
module pmic_ctrl_regs (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr_en,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_rd_en,
  output logic      [7:0] reg_rdata,
  input  wire logic [2:0] conv_en_pin,
  input  wire logic       level_scale_select_pin,
  input  wire logic       brownout_det,
  input  wire logic       thermal_shutdown_det,
  input  wire logic       thermal_warning_det,
  input  wire logic       main_input_lockout_det,
  input  wire logic       conv_supply_lockout_det,
  input  wire logic       switch_supply_lockout_det,
  input  wire logic [1:0] switch_fault_det,
  input  wire logic [2:0] conv_low_det,
  input  wire logic [2:0] conv_good_det,
  output logic            conv1_on,
  output logic            conv2_on,
  output logic            conv3_on,
  output logic            switch1_on,
  output logic            switch2_on,
  output logic      [1:0] conv2_level_code,
  output logic      [1:0] conv3_level_code,
  output logic            event_out,
  output logic            event_oe
);

  // ==========================================================
  // synchronised pins, latched flags and live power-good state
  logic [2:0] pin_sync;
  logic [7:0] stat1_flags;
  logic [2:0] stat2_flags;
  logic [2:0] good_live;
  logic [7:0] stat1_raw;
  logic [3:0] pin_raw;

  assign pin_raw   = {level_scale_select_pin, conv_en_pin};
  assign stat1_raw = {brownout_det,
                      thermal_shutdown_det,
                      thermal_warning_det,
                      main_input_lockout_det,
                      conv_supply_lockout_det,
                      switch_supply_lockout_det,
                      switch_fault_det};

  // ==========================================================
  // address decode shared by the strobes and the read mux
  function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] target);
    return addr == target;
  endfunction

  logic [3:0] pins_s;
  logic       rd_stat1;
  logic       rd_stat2;

  assign rd_stat1 = reg_rd_en && addr_hit(reg_addr, pmic_regs_pkg::ADDR_STAT1);
  assign rd_stat2 = reg_rd_en && addr_hit(reg_addr, pmic_regs_pkg::ADDR_STAT2);

  pmic_cond_sync #(.WIDTH(4), .STICKY(1'b0)) u_pins (
    .clk     (clk),
    .rst_b   (rst_b),
    .raw_i   (pin_raw),
    .clear_i (1'b0),
    .value_o (pins_s)
  );

  pmic_cond_sync #(.WIDTH(pmic_regs_pkg::STAT1_W), .STICKY(1'b1)) u_stat1 (
    .clk     (clk),
    .rst_b   (rst_b),
    .raw_i   (stat1_raw),
    .clear_i (rd_stat1),
    .value_o (stat1_flags)
  );

  pmic_cond_sync #(.WIDTH(pmic_regs_pkg::STAT2_LATCH_W), .STICKY(1'b1)) u_stat2 (
    .clk     (clk),
    .rst_b   (rst_b),
    .raw_i   (conv_low_det),
    .clear_i (rd_stat2),
    .value_o (stat2_flags)
  );

  // power-good is live state: synchronised, never latched
  pmic_cond_sync #(.WIDTH(pmic_regs_pkg::STAT2_GOOD_W), .STICKY(1'b0)) u_good (
    .clk     (clk),
    .rst_b   (rst_b),
    .raw_i   (conv_good_det),
    .clear_i (1'b0),
    .value_o (good_live)
  );

  assign pin_sync = pins_s[2:0];

  // ==========================================================
  // writable registers
  logic [7:0] enable_control_q;
  logic [7:0] rail_level_adjust_q;
  logic       wr_enable;
  logic       wr_adjust;

  assign wr_enable = reg_wr_en && addr_hit(reg_addr, pmic_regs_pkg::ADDR_ENABLE);
  assign wr_adjust = reg_wr_en && addr_hit(reg_addr, pmic_regs_pkg::ADDR_ADJUST);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      enable_control_q    <= pmic_regs_pkg::RST_ENABLE;
      rail_level_adjust_q <= pmic_regs_pkg::RST_ADJUST;
    end else begin
      if (wr_enable) begin
        enable_control_q <= reg_wdata;
      end
      if (wr_adjust) begin
        rail_level_adjust_q <= reg_wdata;
      end
    end
  end

  // ==========================================================
  // effective enables and levels
  logic       level_apply;
  logic [2:0] conv_on_d;
  logic [1:0] conv2_code_d;
  logic [1:0] conv3_code_d;

  assign conv_on_d = {enable_control_q[pmic_regs_pkg::EN_CONV1],
                      enable_control_q[pmic_regs_pkg::EN_CONV2],
                      enable_control_q[pmic_regs_pkg::EN_CONV3]} | pin_sync;
  assign level_apply = enable_control_q[pmic_regs_pkg::EN_LEVEL_SEL] | pins_s[3];
  assign conv2_code_d = level_apply ?
      rail_level_adjust_q[pmic_regs_pkg::ADJ_CONV2_LSB +: pmic_regs_pkg::LEVEL_W] :
      pmic_regs_pkg::LEVEL_NOMINAL;
  assign conv3_code_d = level_apply ?
      rail_level_adjust_q[pmic_regs_pkg::ADJ_CONV3_LSB +: pmic_regs_pkg::LEVEL_W] :
      pmic_regs_pkg::LEVEL_NOMINAL;

  // ==========================================================
  // read mux; data is the value before any clear of the same read
  logic [7:0] rdata_d;
  logic [7:0] stat2_view;
  logic       any_flag;

  assign stat2_view = {pmic_regs_pkg::STAT2_PAD, stat2_flags, good_live};
  assign rdata_d = addr_hit(reg_addr, pmic_regs_pkg::ADDR_ENABLE) ? enable_control_q :
                   addr_hit(reg_addr, pmic_regs_pkg::ADDR_ADJUST) ? rail_level_adjust_q :
                   addr_hit(reg_addr, pmic_regs_pkg::ADDR_STAT1)  ? stat1_flags :
                   addr_hit(reg_addr, pmic_regs_pkg::ADDR_STAT2)  ? stat2_view :
                   pmic_regs_pkg::READ_UNMAP;
  // once both registers are read with no condition still active every latched bit is gone, so one term serves
  assign any_flag = (|stat1_flags) | (|stat2_flags);

  // ==========================================================
  // output flops
  logic [7:0] reg_rdata_q;
  logic [2:0] conv_on_q;
  logic [1:0] switch_on_q;
  logic [1:0] conv2_code_q;
  logic [1:0] conv3_code_q;
  logic       event_oe_q;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata_q  <= pmic_regs_pkg::RST_STAT;
      conv_on_q    <= 3'h0;
      switch_on_q  <= 2'h0;
      conv2_code_q <= pmic_regs_pkg::LEVEL_NOMINAL;
      conv3_code_q <= pmic_regs_pkg::LEVEL_NOMINAL;
      event_oe_q   <= 1'b0;
    end else begin
      if (reg_rd_en) begin
        reg_rdata_q <= rdata_d;
      end
      conv_on_q    <= conv_on_d;
      switch_on_q  <= {enable_control_q[pmic_regs_pkg::EN_SW1],
                       enable_control_q[pmic_regs_pkg::EN_SW2]};
      conv2_code_q <= conv2_code_d;
      conv3_code_q <= conv3_code_d;
      event_oe_q   <= any_flag;
    end
  end

  assign reg_rdata        = reg_rdata_q;
  assign conv1_on         = conv_on_q[2];
  assign conv2_on         = conv_on_q[1];
  assign conv3_on         = conv_on_q[0];
  assign switch1_on       = switch_on_q[1];
  assign switch2_on       = switch_on_q[0];
  assign conv2_level_code = conv2_code_q;
  assign conv3_level_code = conv3_code_q;
  // open drain: only ever pulls low
  assign event_out        = 1'b0;
  assign event_oe         = event_oe_q;

endmodule // pmic_ctrl_regs

// [hw/pmic_regs_pkg.sv]
// Summary of operation
// - enable bit 5 picks nominal or register-coded levels for converters two and three
// - enable bits 4, 3, 2 switch converters one, two, three on
// - enable bits 1 and 0 switch power outputs one and two on
// - converter runs when its register bit or its enable pin is high
// - adjust bits 3:2 set converter two level: nominal, -5%, -10%, -15%
// - adjust bits 1:0 set converter three level with the same coding
// - level codes apply only while level pin or enable bit 5 is high
// - primary status bit 7 latches on input brownout below 9.3 V
// - primary status is read-only; reading it clears every bit except those whose condition is still active
// - event pin released once all latched flags of both status registers are cleared
// - reading secondary status clears only its bits 5 to 3
package pmic_regs_pkg;

  // ==========================================================
  // register map
  localparam int unsigned ADDR_W     = 8;
  localparam int unsigned DATA_W     = 8;
  localparam logic [7:0] ADDR_ENABLE = 8'h00;
  localparam logic [7:0] ADDR_ADJUST = 8'h01;
  localparam logic [7:0] ADDR_STAT1  = 8'h02;
  localparam logic [7:0] ADDR_STAT2  = 8'h03;
  localparam logic [7:0] RST_ENABLE  = 8'h00;
  localparam logic [7:0] RST_ADJUST  = 8'h00;
  localparam logic [7:0] RST_STAT    = 8'h00;
  localparam logic [7:0] READ_UNMAP  = 8'h00;

  // ==========================================================
  // enable register fields
  localparam int unsigned EN_LEVEL_SEL = 5;
  localparam int unsigned EN_CONV1     = 4;
  localparam int unsigned EN_CONV2     = 3;
  localparam int unsigned EN_CONV3     = 2;
  localparam int unsigned EN_SW1       = 1;
  localparam int unsigned EN_SW2       = 0;

  // ==========================================================
  // adjust register fields
  localparam int unsigned ADJ_CONV2_LSB = 2;
  localparam int unsigned ADJ_CONV3_LSB = 0;
  localparam int unsigned LEVEL_W       = 2;
  localparam logic [1:0] LEVEL_NOMINAL  = 2'h0;

  // ==========================================================
  // status fields
  localparam int unsigned STAT1_W       = 8;
  localparam int unsigned STAT2_LATCH_W = 3;
  localparam int unsigned STAT2_LATCH_LSB = 3;
  localparam int unsigned STAT2_GOOD_W  = 3;
  localparam int unsigned BROWNOUT_BIT  = 7;
  localparam logic [1:0] STAT2_PAD      = 2'h0;

endpackage : pmic_regs_pkg

// [testbench/pmic_host_model.sv]
// ==========================================================
// host side of the strobe port: one pulse per access
module pmic_host_model (
  input  wire logic       clk,
  output logic      [7:0] reg_addr,
  output logic            reg_wr_en,
  output logic      [7:0] reg_wdata,
  output logic            reg_rd_en,
  input  wire logic [7:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    reg_addr = 8'h00;
    reg_wr_en = 1'b0;
    reg_wdata = 8'h00;
    reg_rd_en = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = v;
    reg_wr_en = 1'b1;
    @(negedge clk);
    reg_wr_en = 1'b0;
    // stale data is not left on the bus
    reg_wdata = ~v;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(negedge clk);
    reg_addr = a;
    reg_rd_en = 1'b1;
    @(negedge clk);
    reg_rd_en = 1'b0;
    reg_addr = ~a;
    v = reg_rdata;
  endtask
endmodule // pmic_host_model

// [testbench/pmic_regs_assertions.sv]
// ==========================================================
// port checks
module pmic_regs_assertions (
  input wire logic       clk,
  input wire logic       rst_b,
  input wire logic [7:0] reg_addr,
  input wire logic       reg_wr_en,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_rd_en,
  input wire logic [7:0] reg_rdata,
  input wire logic [2:0] conv_en_pin,
  input wire logic       level_scale_select_pin,
  input wire logic       brownout_det,
  input wire logic       thermal_shutdown_det,
  input wire logic       thermal_warning_det,
  input wire logic       main_input_lockout_det,
  input wire logic       conv_supply_lockout_det,
  input wire logic       switch_supply_lockout_det,
  input wire logic [1:0] switch_fault_det,
  input wire logic [2:0] conv_low_det,
  input wire logic [2:0] conv_good_det,
  input wire logic       conv1_on,
  input wire logic       conv2_on,
  input wire logic       conv3_on,
  input wire logic       switch1_on,
  input wire logic       switch2_on,
  input wire logic [1:0] conv2_level_code,
  input wire logic [1:0] conv3_level_code,
  input wire logic       event_oe
);
  wire [7:0]  d1;
  wire [10:0] dl;
  wire        lp, w_en, w_adj, r1, r2;
  assign d1 = {brownout_det, thermal_shutdown_det, thermal_warning_det, main_input_lockout_det,
               conv_supply_lockout_det, switch_supply_lockout_det, switch_fault_det};
  assign dl = {d1, conv_low_det};
  assign lp = level_scale_select_pin;
  assign w_en = reg_wr_en && reg_addr == pmic_regs_pkg::ADDR_ENABLE;
  assign w_adj = reg_wr_en && reg_addr == pmic_regs_pkg::ADDR_ADJUST;
  assign r1 = reg_rd_en && reg_addr == pmic_regs_pkg::ADDR_STAT1;
  assign r2 = reg_rd_en && reg_addr == pmic_regs_pkg::ADDR_STAT2;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  // quiet windows keep pin sync lag out of the comparison
  sw_conv_write_a: assert property (w_en ##1 (!w_en && $stable(conv_en_pin))[*3]
    |=> {conv1_on, conv2_on, conv3_on, switch1_on, switch2_on} ==
    ($past(reg_wdata[4:0], 4) | {$past(conv_en_pin), 2'h0})) else $error("enable outputs wrong");
  pin_force_a: assert property ($rose(conv_en_pin[2]) |-> ##[1:4] conv1_on)
    else $error("pin did not enable converter one");
  code_apply_a: assert property ((w_adj && lp) ##1 (lp && !w_adj)[*3] |=>
    {conv2_level_code, conv3_level_code} == $past(reg_wdata[3:0], 4))
    else $error("level codes not applied");
  code_nominal_a: assert property ((w_en && !reg_wdata[5] && !lp) ##1 (!w_en && !lp)[*3]
    |=> {conv2_level_code, conv3_level_code} == 4'h0) else $error("codes applied when off");
  flag_event_a: assert property ($rose(|dl) |-> ##[3:5] event_oe)
    else $error("event not driven on flag");
  fault_status_primary_read_a: assert property (($stable(d1))[*4] ##0 r1 |=>
    (reg_rdata & $past(d1)) == $past(d1)) else $error("active condition missing in read");
  clear_read_a: assert property ((d1 == 8'h00)[*4] ##0 r1 ##1 (d1 == 8'h00)[*2] ##0 r1
    |=> reg_rdata == 8'h00) else $error("primary status not cleared by read");
  event_release_a: assert property ((dl == 11'h000)[*4] ##0 r1 ##1
    (dl == 11'h000)[*2] ##0 r2 ##1 (dl == 11'h000)[*2] |-> !event_oe)
    else $error("event still driven after reads");
  good_live_a: assert property (($stable(conv_good_det))[*4] ##0 r2 |=>
    reg_rdata[2:0] == $past(conv_good_det) && reg_rdata[7:6] == 2'h0) else $error("bad good bits");
  cover property (r1 ##1 event_oe);
  cover property (w_adj && lp);
  cover property ($fell(event_oe));
endmodule // pmic_regs_assertions
bind pmic_ctrl_regs pmic_regs_assertions chk_u (.*);

// [testbench/testbench.sv]
// ==========================================================
// self-checking bench with integer reference model
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  `define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin fails++; \
    $display("Error t=%0t got %h exp %h", $time, a, e); end end
  logic       clk, rst_b, level_scale_select_pin, reg_wr_en, reg_rd_en, event_out, event_oe;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, f1, d;
  logic [2:0] conv_en_pin, conv_low_det, conv_good_det, cv;
  logic [1:0] sw, conv2_level_code, conv3_level_code;
  logic [3:0] lv;
  int         fails, cmp_count, en_m, adj_m, s1_m, s2_m;
  pmic_ctrl_regs dut_u (.*, .brownout_det(f1[7]), .thermal_shutdown_det(f1[6]),
    .thermal_warning_det(f1[5]), .main_input_lockout_det(f1[4]),
    .conv_supply_lockout_det(f1[3]), .switch_supply_lockout_det(f1[2]),
    .switch_fault_det(f1[1:0]), .conv1_on(cv[2]), .conv2_on(cv[1]), .conv3_on(cv[0]),
    .switch1_on(sw[1]), .switch2_on(sw[0]));
  pmic_host_model host_u (.*);
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // generous: the sequence needs well under 3000 cycles
  initial begin
    #200us;
    fails++;
    end_sim();
  end
  initial begin
    {rst_b, level_scale_select_pin, conv_en_pin, conv_low_det, conv_good_det, f1} = '0;
    void'($urandom(32572));
    repeat (4) @(negedge clk);
    rst_b = 1'b1;
    for (int a = 0; a < 5; a++) begin
      host_u.rd(a == 4 ? 8'h7F : 8'(a), d);
      `CHK(d, 8'h00)
    end
    repeat (24) begin
      en_m = $urandom_range(255);
      adj_m = $urandom_range(255);
      {level_scale_select_pin, conv_en_pin} = 4'($urandom);
      host_u.wr(8'h01, 8'(adj_m));
      host_u.wr(8'h00, 8'(en_m));
      // status places take no writes
      host_u.wr(8'h02 + 8'($urandom_range(1)), 8'($urandom));
      repeat (4) @(negedge clk);
      `CHK(cv, 3'(en_m >> 2) | conv_en_pin)
      `CHK(sw, 2'(en_m))
      lv = (en_m[5] | level_scale_select_pin) ? 4'(adj_m) : 4'h0;
      `CHK({conv2_level_code, conv3_level_code}, lv)
      host_u.rd(8'h00, d);
      `CHK(d, 8'(en_m))
      host_u.rd(8'h01, d);
      `CHK(d, 8'(adj_m))
      s1_m = $urandom_range(255);
      s2_m = $urandom_range(7);
      f1 = 8'(s1_m);
      conv_low_det = 3'(s2_m);
      conv_good_det = 3'($urandom);
      repeat (4) @(negedge clk);
      `CHK(event_oe, 1'((s1_m | s2_m) != 0))
      // reads while the conditions persist: set wins, the flags stay latched
      host_u.rd(8'h02, d);
      `CHK(d, 8'(s1_m))
      host_u.rd(8'h03, d);
      `CHK(d, {2'h0, 3'(s2_m), conv_good_det})
      f1 = 8'h00;
      conv_low_det = 3'h0;
      repeat (4) @(negedge clk);
      host_u.rd(8'h02, d);
      `CHK(d, 8'(s1_m))
      host_u.rd(8'h02, d);
      `CHK(d, 8'h00)
      `CHK(event_oe, 1'(s2_m != 0))
      host_u.rd(8'h03, d);
      `CHK(d, {2'h0, 3'(s2_m), conv_good_det})
      host_u.rd(8'h03, d);
      `CHK(d, {5'h00, conv_good_det})
      `CHK({event_oe, event_out}, 2'h0)
    end
    // reset in mid-run with a condition present
    f1 = 8'h81;
    rst_b = 1'b0;
    repeat (2) @(negedge clk);
    `CHK({cv, sw, conv2_level_code, conv3_level_code, event_oe, reg_rdata}, 18'h00000)
    rst_b = 1'b1;
    host_u.rd(8'h00, d);
    `CHK(d, 8'h00)
    repeat (4) @(negedge clk);
    `CHK(event_oe, 1'b1)
    host_u.rd(8'h02, d);
    `CHK(d, 8'h81)
    end_sim();
  end
endmodule // testbench
